// *** common/dcp_pkg.sv ***
// Package of constants and types for the down counter with PWM output.
package dcp_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_VALUE = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_CTRL2 = 3'h2;
  localparam logic [2:0] ADDR_DUTY = 3'h3;
  localparam logic [2:0] ADDR_HIGH = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;
  localparam logic [2:0] ADDR_PRESC = 3'h7;
  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam int CTL_EN = 0;
  localparam int CTL_RL = 1;
  localparam int CTL_OS = 2;
  localparam int CTL_MOE = 5;
  localparam int CTL_PAL = 6;
  localparam int CTL_POE = 7;
  localparam int C2_CS = 5;
  localparam int C2_CE = 4;
  localparam int C2_PSD = 3;
  localparam int HI_RLD = 4;
  localparam int HI_DUTY = 0;
  localparam int IRQ_UF = 0;
  localparam int IRQ_PWM = 1;
  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h3f;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [9:0] CNT_FULL = 10'h3ff;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;
  localparam logic [7:0] PS_ONE = 8'h01;
  localparam logic [7:0] PS_RST = 8'hff;
  // Decoded control word.
  typedef struct packed {
    logic pwm_pin_enable;
    logic pwm_active_low;
    logic match_toggle_pin_enable;
    logic one_shot_select;
    logic reload_from_stored_value;
    logic counter_enable;
  } dcp_ctrl_t;
  // Pin drive bundle.
  typedef struct packed {
    logic o;
    logic oe;
  } dcp_pin_t;
endpackage : dcp_pkg

// *** logic/dcp_down_counter.sv ***
// Ten-bit down counter with prescaler, PWM and underflow toggle output.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Reading count register returns live count, upper two bits in shared high register.
// - Writing count stores reload with high-register bits and loads running count.
// - One-shot mode counts down to zero then stops, ignoring reload select.
// - Free-running mode keeps counting after every underflow.
// - Free-running with reload select one reloads the stored value on underflow.
// - Free-running with reload select zero reloads full scale on underflow.
// - PWM polarity bit one makes output active low, zero active high.
// - PWM enable puts PWM waveform on port B pin four; with neither PWM nor match enable, port control.
// - Match output toggles per underflow and drives the pin when enabled.
// - Underflow toggle output has priority over PWM on the shared pin.
// - Clock source picks instruction clock or external pin; edge bit picks edge.
// - Active-low enabled prescaler divides by two to 256 via three-bit code.
// - Reload sets PWM period; ten-bit duty from high register and duty register.
module dcp_down_counter (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic inst_tick, // Instruction clock enable pulse.
  input wire logic ext_clk_pin, // External counter clock pin level.
  input wire logic [2:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
  input wire logic gpio_out, // Port pin output level from port logic.
  input wire logic gpio_oe, // Port pin output enable from port logic.
  output logic port_b_pin_four_o, // Port B pin four output level.
  output logic port_b_pin_four_oe, // Port B pin four output enable.
  output logic underflow_toggle_out, // Underflow toggle signal.
  output logic irq // Level interrupt.
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [9:0] count_r, count_nxt;
  logic [9:0] reload_r;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl2_r;
  logic [7:0] duty_r;
  logic [7:0] high_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  logic [7:0] presc_r;
  logic ext_d_r;
  logic toggle_r;
  logic stopped_r;
  logic pwm_r;
  logic [7:0] rdata_r;
  dcp_pkg::dcp_ctrl_t ctl;
  dcp_pkg::dcp_pin_t pin;

  assign ctl = '{pwm_pin_enable: ctrl_r[dcp_pkg::CTL_POE],
                 pwm_active_low: ctrl_r[dcp_pkg::CTL_PAL],
                 match_toggle_pin_enable: ctrl_r[dcp_pkg::CTL_MOE],
                 one_shot_select: ctrl_r[dcp_pkg::CTL_OS],
                 reload_from_stored_value: ctrl_r[dcp_pkg::CTL_RL],
                 counter_enable: ctrl_r[dcp_pkg::CTL_EN]};

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire wr_value = reg_wr && (reg_addr == dcp_pkg::ADDR_VALUE);
  wire wr_ctrl = reg_wr && (reg_addr == dcp_pkg::ADDR_CTRL);
  wire wr_ctrl2 = reg_wr && (reg_addr == dcp_pkg::ADDR_CTRL2);
  wire wr_duty = reg_wr && (reg_addr == dcp_pkg::ADDR_DUTY);
  wire wr_high = reg_wr && (reg_addr == dcp_pkg::ADDR_HIGH);
  wire wr_stat = reg_wr && (reg_addr == dcp_pkg::ADDR_IRQ_STAT);
  wire wr_mask = reg_wr && (reg_addr == dcp_pkg::ADDR_IRQ_MASK);

  // ----------------------------------------------------------------------
  // Clock source, edge and prescaler
  // ----------------------------------------------------------------------
  wire [2:0] prescale_rate_code = ctrl2_r[2:0];
  wire prescale_disable_n = ctrl2_r[dcp_pkg::C2_PSD];
  wire counter_edge_select = ctrl2_r[dcp_pkg::C2_CE];
  wire counter_clock_source = ctrl2_r[dcp_pkg::C2_CS];
  wire ext_rise = ext_clk_pin && !ext_d_r;
  wire ext_fall = !ext_clk_pin && ext_d_r;
  wire ext_edge = counter_edge_select ? ext_fall : ext_rise;
  wire src_tick = counter_clock_source ? ext_edge : inst_tick;
  wire [7:0] presc_dec = presc_r - dcp_pkg::PS_ONE;
  // The prescaler counts down; bit k falling marks a divide by 2^(k+1).
  wire presc_tick = src_tick && presc_r[prescale_rate_code] && !presc_dec[prescale_rate_code];
  wire cnt_tick = prescale_disable_n ? src_tick : presc_tick;

  // ----------------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------------
  wire at_zero = (count_r == dcp_pkg::CNT_ZERO);
  wire do_dec = ctl.counter_enable && cnt_tick && !stopped_r;
  wire underflow = do_dec && at_zero;
  wire [9:0] reload_src = ctl.reload_from_stored_value ? reload_r : dcp_pkg::CNT_FULL;
  wire [9:0] wr_reload = {high_r[dcp_pkg::HI_RLD +: 2], reg_wdata};
  wire [9:0] duty_val = {high_r[dcp_pkg::HI_DUTY +: 2], duty_r};

  always_comb begin
    count_nxt = count_r;
    if (wr_value) begin
      count_nxt = wr_reload;
    end else if (do_dec) begin
      if (!at_zero) begin
        count_nxt = count_r - dcp_pkg::CNT_ONE;
      end else if (!ctl.one_shot_select) begin
        count_nxt = reload_src;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequential state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= dcp_pkg::CNT_ZERO;
      reload_r <= dcp_pkg::CNT_ZERO;
      ext_d_r <= 1'b0;
      presc_r <= dcp_pkg::PS_RST;
    end else begin
      count_r <= count_nxt;
      ext_d_r <= ext_clk_pin;
      if (wr_value) begin
        reload_r <= wr_reload;
      end
      if (prescale_disable_n || wr_ctrl2) begin
        presc_r <= dcp_pkg::PS_RST;
      end else if (src_tick) begin
        presc_r <= presc_dec;
      end
    end
  end

  // One-shot stops after reaching zero; a count write or leaving one-shot rearms.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stopped_r <= 1'b0;
    end else if (wr_value || !ctl.one_shot_select) begin
      stopped_r <= 1'b0;
    end else if (underflow) begin
      stopped_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;
    end else if (underflow) begin
      toggle_r <= !toggle_r;
    end
  end

  // PWM is active while the count lies below the duty value within the reload frame.
  wire pwm_active = (count_r < duty_val);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_active ^ ctl.pwm_active_low;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= dcp_pkg::CTRL_RST;
      ctrl2_r <= dcp_pkg::CTRL2_RST;
      duty_r <= dcp_pkg::ZERO8;
      high_r <= dcp_pkg::ZERO8;
      irq_mask_r <= 2'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata;
      if (wr_ctrl2) ctrl2_r <= reg_wdata;
      if (wr_duty) duty_r <= reg_wdata;
      if (wr_high) high_r <= reg_wdata;
      if (wr_mask) irq_mask_r <= reg_wdata[1:0];
    end
  end

  // Sticky events: a set in the same cycle as a write-one clear wins.
  wire pwm_start = underflow;
  logic [1:0] irq_set;
  assign irq_set = {pwm_start && ctl.pwm_pin_enable, underflow};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | irq_set;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      dcp_pkg::ADDR_VALUE: rd_mux = count_r[7:0];
      dcp_pkg::ADDR_CTRL: rd_mux = ctrl_r & 8'he7;
      dcp_pkg::ADDR_CTRL2: rd_mux = ctrl2_r & 8'h3f;
      dcp_pkg::ADDR_DUTY: rd_mux = duty_r;
      dcp_pkg::ADDR_HIGH: rd_mux = {high_r[7:6], count_r[9:8], high_r[3:0]};
      dcp_pkg::ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_r};
      dcp_pkg::ADDR_IRQ_MASK: rd_mux = {6'h00, irq_mask_r};
      dcp_pkg::ADDR_PRESC: rd_mux = presc_r;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= dcp_pkg::ZERO8;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= dcp_pkg::ZERO8;
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------------
  always_comb begin
    if (ctl.match_toggle_pin_enable) begin
      pin = '{o: toggle_r, oe: 1'b1};
    end else if (ctl.pwm_pin_enable) begin
      pin = '{o: pwm_r, oe: 1'b1};
    end else begin
      pin = '{o: gpio_out, oe: gpio_oe};
    end
  end
  assign port_b_pin_four_o = pin.o;
  assign port_b_pin_four_oe = pin.oe;
  assign underflow_toggle_out = toggle_r;
endmodule // dcp_down_counter
`default_nettype wire

// *** tb/dcp_down_counter_properties.sv ***
// Port-level checker for the down counter with PWM output.
`timescale 1ns/100ps
`default_nettype none
module dcp_checker (
  input wire logic clk_sys, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic [2:0] reg_addr, // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic gpio_out, // Port level.
  input wire logic gpio_oe, // Port enable.
  input wire logic port_b_pin_four_o, // Pin level.
  input wire logic port_b_pin_four_oe, // Pin enable.
  input wire logic underflow_toggle_out, // Toggle.
  input wire logic irq // Interrupt.
);
  logic [7:0] ctl_r;
  logic [7:0] msk_r;
  logic [9:0] duty_r;
  wire logic moe = ctl_r[dcp_pkg::CTL_MOE];
  wire logic poe = ctl_r[dcp_pkg::CTL_POE];
  wire logic en = ctl_r[dcp_pkg::CTL_EN];
  // Shadows of the control, mask and duty writes seen on the bus.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 8'h00;
      msk_r <= 8'h00;
      duty_r <= 10'h000;
    end else if (reg_wr) begin
      if (reg_addr == dcp_pkg::ADDR_CTRL) ctl_r <= reg_wdata;
      if (reg_addr == dcp_pkg::ADDR_IRQ_MASK) msk_r <= reg_wdata;
      if (reg_addr == dcp_pkg::ADDR_DUTY) duty_r[7:0] <= reg_wdata;
      if (reg_addr == dcp_pkg::ADDR_HIGH) duty_r[9:8] <= reg_wdata[1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a); reg_wr && reg_addr == a && !en; endsequence
  sequence s_rd(a); reg_rd && reg_addr == a && !en; endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  a_ctrl_readback: assert property (s_wr(dcp_pkg::ADDR_CTRL) ##1 s_rd(dcp_pkg::ADDR_CTRL)
    |=> (reg_rdata & 8'he7) == ($past(reg_wdata, 2) & 8'he7))
    else $error("control readback wrong");
  a_count_readback: assert property (s_wr(dcp_pkg::ADDR_VALUE) ##1 s_rd(dcp_pkg::ADDR_VALUE)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("count readback wrong");
  a_hold_disabled: assert property (!en && !$past(en) && !$past(en, 2)
    |-> $stable(underflow_toggle_out))
    else $error("toggle moved while disabled");
  a_gpio_pass: assert property (!moe && !poe && !$past(moe) && !$past(poe)
    |-> port_b_pin_four_oe == gpio_oe && port_b_pin_four_o == gpio_out)
    else $error("pin not under port control");
  a_toggle_pin: assert property (moe && $past(moe) |-> port_b_pin_four_oe &&
    (port_b_pin_four_o == underflow_toggle_out || port_b_pin_four_o == $past(underflow_toggle_out)))
    else $error("pin not driven by toggle");
  a_pwm_level: assert property (poe && !moe && $stable(ctl_r) && $stable(duty_r) && duty_r == 10'h000
    |-> port_b_pin_four_oe && port_b_pin_four_o == ctl_r[dcp_pkg::CTL_PAL])
    else $error("pwm idle level wrong");
  a_irq_masked: assert property (msk_r[1:0] == 2'b00 && $past(msk_r[1:0]) == 2'b00 |-> !irq)
    else $error("interrupt while masked");
  a_underflow_irq: assert property ($changed(underflow_toggle_out) && msk_r[0]
    |-> ##[1:2] irq)
    else $error("underflow did not interrupt");
endmodule // dcp_checker
bind dcp_down_counter dcp_checker u_props (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .gpio_out, .gpio_oe, .port_b_pin_four_o, .port_b_pin_four_oe,
  .underflow_toggle_out, .irq);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the down counter with PWM output.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic inst_tick = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic pin_o, pin_oe, tog, irq;
  int num_errors = 0;
  int n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  dcp_down_counter uut (.clk_sys, .rst_n, .inst_tick, .ext_clk_pin, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .gpio_out, .gpio_oe, .port_b_pin_four_o(pin_o),
    .port_b_pin_four_oe(pin_oe), .underflow_toggle_out(tog), .irq);
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus tasks start and end one nanosecond after a rising edge.
  task automatic wr(logic [2:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e & m, reg_rdata & m);
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      inst_tick <= 1'b1;
      @(posedge clk_sys);
      inst_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    #1;
  endtask
  task automatic ext(logic v, logic [7:0] e);
    ext_clk_pin <= v;
    repeat (4) @(posedge clk_sys);
    #1;
    rd(dcp_pkg::ADDR_VALUE, e);
  endtask
  task automatic pin(logic [7:0] c, logic [1:0] e);
    wr(dcp_pkg::ADDR_CTRL, c);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("pin", 8'(e), 8'({pin_o, pin_oe}));
  endtask
  task automatic irq_is(logic e);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", 8'(e), 8'(irq));
  endtask
  task automatic sc_reset();
    rd(dcp_pkg::ADDR_CTRL, dcp_pkg::CTRL_RST, 8'he7);
    rd(dcp_pkg::ADDR_CTRL2, dcp_pkg::CTRL2_RST, 8'h3f);
    rd(dcp_pkg::ADDR_VALUE, 8'h00);
    wr(dcp_pkg::ADDR_CTRL, 8'he6);
    rd(dcp_pkg::ADDR_CTRL, 8'he6, 8'he7);
    wr(dcp_pkg::ADDR_CTRL, 8'h00);
  endtask
  task automatic sc_hold();
    wr(dcp_pkg::ADDR_CTRL2, 8'h08);
    wr(dcp_pkg::ADDR_HIGH, 8'h20);
    wr(dcp_pkg::ADDR_VALUE, 8'h34);
    rd(dcp_pkg::ADDR_VALUE, 8'h34);
    ticks(2);
    rd(dcp_pkg::ADDR_VALUE, 8'h34);
    rd(dcp_pkg::ADDR_HIGH, 8'h20);
  endtask
  task automatic sc_modes();
    wr(dcp_pkg::ADDR_HIGH, 8'h00);
    wr(dcp_pkg::ADDR_VALUE, 8'h03);
    wr(dcp_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(dcp_pkg::ADDR_CTRL, 8'h05);
    ticks(3);
    chk("toggle", 8'h00, 8'(tog));
    ticks(3);
    rd(dcp_pkg::ADDR_VALUE, 8'h00);
    chk("toggle", 8'h01, 8'(tog));
    irq_is(1'b1);
    wr(dcp_pkg::ADDR_IRQ_STAT, 8'h01);
    irq_is(1'b0);
    wr(dcp_pkg::ADDR_VALUE, 8'h03);
    wr(dcp_pkg::ADDR_CTRL, 8'h03);
    ticks(6);
    rd(dcp_pkg::ADDR_VALUE, 8'h01);
    wr(dcp_pkg::ADDR_IRQ_MASK, 8'h00);
    irq_is(1'b0);
    wr(dcp_pkg::ADDR_IRQ_MASK, 8'h01);
    irq_is(1'b1);
    wr(dcp_pkg::ADDR_IRQ_STAT, 8'h01);
    irq_is(1'b0);
    wr(dcp_pkg::ADDR_VALUE, 8'h01);
    wr(dcp_pkg::ADDR_CTRL, 8'h01);
    ticks(3);
    rd(dcp_pkg::ADDR_VALUE, 8'hfe);
    rd(dcp_pkg::ADDR_HIGH, 8'h30);
    chk("toggle", 8'h01, 8'(tog));
  endtask
  task automatic sc_clocks();
    wr(dcp_pkg::ADDR_VALUE, 8'h40);
    for (int c = 0; c < 3; c++) begin
      wr(dcp_pkg::ADDR_CTRL2, 8'(c));
      ticks(2 << c);
      rd(dcp_pkg::ADDR_VALUE, 8'h3f - 8'(c));
    end
    rd(dcp_pkg::ADDR_PRESC, 8'hf7);
    wr(dcp_pkg::ADDR_CTRL2, 8'h28);
    wr(dcp_pkg::ADDR_VALUE, 8'h10);
    ext(1'b1, 8'h0f);
    ext(1'b0, 8'h0f);
    wr(dcp_pkg::ADDR_CTRL2, 8'h38);
    ext(1'b1, 8'h0f);
    ext(1'b0, 8'h0e);
  endtask
  task automatic sc_pins();
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    pin(8'h00, 2'b11);
    gpio_out <= 1'b0;
    gpio_oe <= 1'b0;
    pin(8'hc0, 2'b11);
    pin(8'h80, 2'b01);
    pin(8'ha0, 2'b11);
    pin(8'h20, 2'b11);
    wr(dcp_pkg::ADDR_DUTY, 8'h50);
    pin(8'h80, 2'b11);
    pin(8'hc0, 2'b01);
    pin(8'h00, 2'b00);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    sc_reset();
    sc_hold();
    sc_modes();
    sc_clocks();
    sc_pins();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
